// file: dv/dwv_media_model.sv
// media engine model: answers each med_start after a set delay and feeds compare pairs
// assumes the decoder clock and at most one media operation in flight
`timescale 1ns/1ps
module dwv_media_model (
    input wire logic clock,
    input wire logic reset,
    input wire dwv_pkg::dwv_media_t med_cmd,
    input wire logic med_start,
    input wire logic [7:0] dly,
    input wire logic err_in,
    input wire logic bad_in,
    output logic med_done,
    output logic med_error,
    output logic cmp_host_valid,
    output logic [7:0] cmp_host_byte,
    output logic cmp_med_valid,
    output logic [7:0] cmp_med_byte
);
    logic [7:0] cnt_q;
    logic run_q;
    logic feed;
    assign feed = run_q && med_cmd.compare && cnt_q != 8'h00;
    // ************************************************************
    // operation timing and compare stream
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            run_q <= 1'b0;
            med_done <= 1'b0;
            med_error <= 1'b0;
        end else begin
            med_done <= run_q && cnt_q == 8'h00;
            med_error <= run_q && cnt_q == 8'h00 && err_in;
            if (med_start) begin
                run_q <= 1'b1;
                cnt_q <= dly;
            end else if (run_q) begin
                run_q <= cnt_q != 8'h00;
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
    // idle bytes toggle so a stale byte can never pass for a match
    always_ff @(posedge clock) begin
        cmp_host_valid <= feed;
        cmp_med_valid <= feed;
        cmp_host_byte <= feed ? cnt_q : ~cmp_host_byte;
        cmp_med_byte <= feed ? cnt_q ^ {7'h00, bad_in} : ~cmp_med_byte;
    end
endmodule

// file: dv/tb.sv
// self-checking bench for the write/verify command decoder
// assumes the media model on the far side and Avalon-MM tasks as the only host path
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic spindle_ready = 1'b0;
    logic [7:0] dly = 8'h04;
    logic err_in = 1'b0;
    logic bad_in = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, med_start, med_done, med_error, cmd_done, hv, mv;
    logic [7:0] hb, mb;
    dwv_pkg::dwv_media_t med_cmd, seen_q;
    int n_fail = 0;
    int n_checks = 0;
    time t_mdone, t_cmd;
    localparam logic [20:0] GOOD_R = {1'b0, dwv_pkg::KEY_NONE, dwv_pkg::ASC_NONE, 8'h00};
    always #2 clock = ~clock;
    dwv_decoder u_dut (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .spindle_ready(spindle_ready), .med_cmd(med_cmd), .med_start(med_start),
        .med_done(med_done), .med_error(med_error), .cmp_host_valid(hv),
        .cmp_host_byte(hb), .cmp_med_valid(mv), .cmp_med_byte(mb), .cmd_done(cmd_done));
    dwv_media_model u_med (.clock(clock), .reset(reset), .med_cmd(med_cmd),
        .med_start(med_start), .dly(dly), .err_in(err_in), .bad_in(bad_in),
        .med_done(med_done), .med_error(med_error), .cmp_host_valid(hv),
        .cmp_host_byte(hb), .cmp_med_valid(mv), .cmp_med_byte(mb));
    always @(posedge clock) begin
        if (med_start === 1'b1) seen_q <= med_cmd;
        if (med_done === 1'b1) t_mdone <= $time;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge; read data taken at
    // that edge; one edge passes before the next request, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [79:0] c10(input logic [7:0] op, input logic [7:0] b1,
        input logic [31:0] lba, input logic [15:0] n, input logic [7:0] ctl);
        return {ctl, n[7:0], n[15:8], 8'h00, lba[7:0], lba[15:8], lba[23:16], lba[31:24],
            b1, op};
    endfunction
    function automatic logic [20:0] chk(input logic [3:0] k, input logic [7:0] a);
        return {1'b0, k, a, dwv_pkg::STS_CHECK};
    endfunction
    task automatic chk_med(input dwv_pkg::dwv_mop_t op, input logic [31:0] lba,
        input logic [16:0] n, input logic c);
        check({12'h000, seen_q}, {12'h000, op, lba, n, c});
    endtask
    task automatic run_cmd(input logic [79:0] cdb, input logic wce, input logic [20:0] exp);
        int n;
        n = 0;
        bus(1'b1, dwv_pkg::REG_CDB_LO, cdb[31:0]);
        bus(1'b1, dwv_pkg::REG_CDB_MID, cdb[63:32]);
        bus(1'b1, dwv_pkg::REG_CDB_HI, {16'h0000, cdb[79:64]});
        bus(1'b1, dwv_pkg::REG_CTRL, {30'h0, wce, 1'b1});
        while (cmd_done !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        t_cmd = $time;
        @(posedge clock);
        rd = 32'hFFFFFFFF;
        while (rd[21] !== 1'b0 && n < 600) begin
            bus(1'b0, dwv_pkg::REG_STATUS, 32'h0);
            n++;
        end
        if (n >= 500) n_fail++;
        check({43'h0, rd[20:0]}, {43'h0, exp});
    endtask
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        run_cmd(80'h0, 1'b0, chk(4'h2, 8'h04));
        spindle_ready <= 1'b1;
        run_cmd(80'h0, 1'b0, GOOD_R);
        run_cmd(c10(8'h2F, 8'h00, 32'h64, 16'h0003, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_VERIFY, 32'h64, 17'h00003, 1'b0);
        bad_in <= 1'b1;
        run_cmd(c10(8'h2F, 8'h02, 32'h64, 16'h0002, 8'h00), 1'b0, chk(4'hE, 8'h1D));
        bad_in <= 1'b0;
        err_in <= 1'b1;
        run_cmd(c10(8'h2F, 8'h00, 32'h64, 16'h0002, 8'h00), 1'b0, chk(4'h3, 8'h11));
        err_in <= 1'b0;
        run_cmd(c10(8'h2F, 8'h00, 32'hC8, 16'h0000, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_SEEK, 32'hC8, 17'h00000, 1'b0);
        run_cmd(c10(8'h2F, 8'h02, 32'h0, 16'h0041, 8'h00), 1'b0, chk(4'h5, 8'h24));
        run_cmd(c10(8'h2F, 8'h02, 32'h0, 16'h0040, 8'h00), 1'b0, GOOD_R);
        run_cmd(c10(8'h2F, 8'h10, 32'h0, 16'h0001, 8'h00), 1'b0, chk(4'h5, 8'h24));
        run_cmd(c10(8'h3B, 8'h00, 32'h0, 16'h0001, 8'h00), 1'b0, chk(4'h5, 8'h20));
        run_cmd({48'h0, 8'h00, 8'hDE, 8'hBC, 8'h1A, 8'h0A}, 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_WRITE, 32'h1ABCDE, 17'h00100, 1'b0);
        dly <= 8'h0A;
        run_cmd(c10(8'h2A, 8'h08, 32'h3E8, 16'h0004, 8'h01), 1'b0, GOOD_R);
        check(t_cmd - t_mdone, 64'h2);
        chk_med(dwv_pkg::MOP_WRITE, 32'h3E8, 17'h00004, 1'b0);
        run_cmd(c10(8'h2A, 8'h09, 32'hFFFFFFFE, 16'h0001, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_WRITE, 32'h3E9, 17'h00001, 1'b0);
        bus(1'b0, dwv_pkg::REG_LAST_LBA, 32'h0);
        check({32'h0, rd}, 64'h3E9);
        run_cmd(c10(8'h2A, 8'h09, 32'h5, 16'h0001, 8'h00), 1'b0, chk(4'h5, 8'h24));
        run_cmd(c10(8'h2A, 8'h00, 32'h12C, 16'h0000, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_SEEK, 32'h12C, 17'h00000, 1'b0);
        dly <= 8'h28;
        err_in <= 1'b1;
        run_cmd(c10(8'h2A, 8'h00, 32'h190, 16'h0002, 8'h00), 1'b1, GOOD_R);
        check({63'h0, t_mdone > t_cmd}, 64'h1);
        err_in <= 1'b0;
        run_cmd(80'h0, 1'b1, {1'b1, 4'h3, 8'h0C, 8'h02});
        run_cmd(80'h0, 1'b1, GOOD_R);
        dly <= 8'h04;
        run_cmd(c10(8'h2E, 8'h00, 32'h1F4, 16'h0002, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_WRITE_VERIFY, 32'h1F4, 17'h00002, 1'b0);
        bad_in <= 1'b1;
        run_cmd(c10(8'h2E, 8'h02, 32'h1F4, 16'h0002, 8'h00), 1'b0, chk(4'hE, 8'h1D));
        bad_in <= 1'b0;
        run_cmd(c10(8'h2E, 8'h00, 32'h258, 16'h0000, 8'h00), 1'b0, GOOD_R);
        chk_med(dwv_pkg::MOP_SEEK, 32'h258, 17'h00000, 1'b0);
        bus(1'b0, 4'hA, 32'h0);
        check({32'h0, rd}, 64'h0);
        report_and_stop();
    end
endmodule

// file: src/dwv_decoder.sv
// disk write/verify command decoder: parses descriptors written over Avalon-MM, drives a
// media engine and reports status and sense. assumes a media engine on the same clock that
// pulses med_done once per started operation, after its last compare byte pair.
//
// Contract
// - ready check returns good when spindle ready
// - not at speed: check, not ready sense
// - verify fields: flags, address, count decoded
// - verify without bytck: media check, no compare
// - verify bytck: compare initiator data, miscompare sense
// - unreadable media during verify: medium error
// - verify count zero verifies nothing, no error
// - bytck over 32768 bytes: illegal request
// - short write: 21-bit address, byte count
// - long write: fua, reladr, address, count decoded
// - short write count zero means 256
// - long write count zero is seek
// - fua write: good only after media done
// - cached write may report good early
// - late cached error reported on next command
// - relative address adds signed offset, linked only
// - absolute address otherwise
// - write and verify: write then verify
// - write verify without bytck: ecc only
// - write verify bytck: compare, miscompare sense
// - write verify count zero is seek
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dwv_decoder (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic spindle_ready,
    output dwv_pkg::dwv_media_t med_cmd,
    output logic med_start,
    input wire logic med_done,
    input wire logic med_error,
    input wire logic cmp_host_valid,
    input wire logic [7:0] cmp_host_byte,
    input wire logic cmp_med_valid,
    input wire logic [7:0] cmp_med_byte,
    output logic cmd_done
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DECODE = 3'b010,
        ST_MEDIA = 3'b100
    } dwv_state_t;

    dwv_state_t state_q;
    logic [79:0] cdb_q;
    logic wce_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic spin_meta_q;
    logic spin_q;
    dwv_pkg::dwv_result_t result_q;
    logic busy_q;
    logic cached_q;
    logic early_q;
    logic deferred_q;
    logic mismatch_q;
    logic [31:0] last_lba_q;
    logic link_ok_q;
    logic link_cmd_q;
    dwv_pkg::dwv_media_t med_q;
    logic med_start_q;
    logic done_q;

    logic acc;
    logic go;
    logic pair_diff;
    logic miss;
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [31:0] lba_field;
    logic [16:0] count;
    logic [31:0] lba_eff;
    logic is_data_cmd;
    logic bytck;
    logic reladr;
    logic link_bit;
    logic bad_field;
    logic cached_write;
    dwv_pkg::dwv_mop_t mop;

    // ************************************************************
    // avalon slave
    // ************************************************************
    // one wait cycle per access: the access is taken where waitrequest reads low
    assign acc = (avs_read || avs_write) && !wait_q;
    assign go = avs_write && !wait_q && avs_address == dwv_pkg::REG_CTRL
        && avs_writedata[dwv_pkg::CTRL_GO_BIT];

    always_ff @(posedge clock) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read && wait_q) begin
            case (avs_address)
                dwv_pkg::REG_CDB_LO: rdata_q <= cdb_q[31:0];
                dwv_pkg::REG_CDB_MID: rdata_q <= cdb_q[63:32];
                dwv_pkg::REG_CDB_HI: rdata_q <= {16'h0000, cdb_q[79:64]};
                dwv_pkg::REG_CTRL: rdata_q <= {30'h00000000, wce_q, 1'b0};
                dwv_pkg::REG_STATUS: rdata_q <= {9'h000, deferred_q, busy_q,
                    result_q.deferred, result_q.key, result_q.asc, result_q.status};
                dwv_pkg::REG_LAST_LBA: rdata_q <= last_lba_q;
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    // descriptor is frozen while a command runs so decode sees stable bytes
    always_ff @(posedge clock) begin
        if (reset) begin
            cdb_q <= 80'h0;
            wce_q <= dwv_pkg::CTRL_WCE_RESET;
        end else if (acc && avs_write && !busy_q) begin
            case (avs_address)
                dwv_pkg::REG_CDB_LO: cdb_q[31:0] <= avs_writedata;
                dwv_pkg::REG_CDB_MID: cdb_q[63:32] <= avs_writedata;
                dwv_pkg::REG_CDB_HI: cdb_q[79:64] <= avs_writedata[15:0];
                dwv_pkg::REG_CTRL: wce_q <= avs_writedata[dwv_pkg::CTRL_WCE_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            spin_meta_q <= 1'b0;
            spin_q <= 1'b0;
        end else begin
            spin_meta_q <= spindle_ready;
            spin_q <= spin_meta_q;
        end
    end

    // ************************************************************
    // descriptor decode
    // ************************************************************
    always_comb begin
        opcode = cdb_q[7:0];
        b1 = cdb_q[15:8];
        is_data_cmd = 1'b1;
        bytck = 1'b0;
        reladr = 1'b0;
        link_bit = cdb_q[72 + dwv_pkg::CTRL_LINK];
        lba_field = {cdb_q[23:16], cdb_q[31:24], cdb_q[39:32], cdb_q[47:40]};
        count = {1'b0, cdb_q[63:56], cdb_q[71:64]};
        mop = dwv_pkg::MOP_SEEK;
        bad_field = 1'b0;
        case (opcode)
            dwv_pkg::OP_WRITE6: begin
                lba_field = {11'h000, b1[4:0], cdb_q[23:16], cdb_q[31:24]};
                count = (cdb_q[39:32] == 8'h00) ? dwv_pkg::WRITE6_ZERO_COUNT
                    : {9'h000, cdb_q[39:32]};
                link_bit = cdb_q[40 + dwv_pkg::CTRL_LINK];
                mop = dwv_pkg::MOP_WRITE;
            end
            dwv_pkg::OP_WRITE10: begin
                reladr = b1[dwv_pkg::B1_RELADR];
                mop = (count == 17'h00000) ? dwv_pkg::MOP_SEEK : dwv_pkg::MOP_WRITE;
            end
            dwv_pkg::OP_VERIFY: begin
                reladr = b1[dwv_pkg::B1_RELADR];
                bytck = b1[dwv_pkg::B1_BYTCK];
                bad_field = b1[dwv_pkg::B1_DPO];
                mop = (count == 17'h00000) ? dwv_pkg::MOP_SEEK : dwv_pkg::MOP_VERIFY;
            end
            dwv_pkg::OP_WRITE_VERIFY: begin
                reladr = b1[dwv_pkg::B1_RELADR];
                bytck = b1[dwv_pkg::B1_BYTCK];
                bad_field = b1[dwv_pkg::B1_DPO];
                mop = (count == 17'h00000) ? dwv_pkg::MOP_SEEK
                    : dwv_pkg::MOP_WRITE_VERIFY;
            end
            default: is_data_cmd = 1'b0;
        endcase
        // relative offset needs an earlier data access in the same linked group
        if (reladr && !link_ok_q) begin
            bad_field = 1'b1;
        end
        if (bytck && count > dwv_pkg::BYTCK_MAX_BLOCKS) begin
            bad_field = 1'b1;
        end
    end

    // two's complement wraps naturally in the 32-bit sum
    assign lba_eff = reladr ? last_lba_q + lba_field : lba_field;
    assign cached_write = mop == dwv_pkg::MOP_WRITE && !b1[dwv_pkg::B1_FUA] && wce_q
        && opcode == dwv_pkg::OP_WRITE10;
    assign pair_diff = cmp_host_valid && cmp_med_valid && cmp_host_byte != cmp_med_byte;
    assign miss = mismatch_q || pair_diff;

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            result_q <= '{dwv_pkg::STS_GOOD, dwv_pkg::KEY_NONE, dwv_pkg::ASC_NONE, 1'b0};
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // a go while still busy (incl. a cached write draining) is dropped
                    if (go && !busy_q) begin
                        state_q <= ST_DECODE;
                        busy_q <= 1'b1;
                    end else if (early_q && med_done) begin
                        busy_q <= 1'b0;
                    end
                end
                ST_DECODE: begin
                    if (deferred_q) begin
                        result_q <= '{dwv_pkg::STS_CHECK, dwv_pkg::KEY_MEDIUM,
                            dwv_pkg::ASC_WRITE_ERR, 1'b1};
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else if (opcode == dwv_pkg::OP_TEST_READY) begin
                        result_q <= spin_q
                            ? '{dwv_pkg::STS_GOOD, dwv_pkg::KEY_NONE, dwv_pkg::ASC_NONE, 1'b0}
                            : '{dwv_pkg::STS_CHECK, dwv_pkg::KEY_NOT_READY,
                                dwv_pkg::ASC_NOT_READY, 1'b0};
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else if (!is_data_cmd || bad_field) begin
                        result_q <= '{dwv_pkg::STS_CHECK, dwv_pkg::KEY_ILLEGAL,
                            is_data_cmd ? dwv_pkg::ASC_BAD_FIELD : dwv_pkg::ASC_BAD_OPCODE,
                            1'b0};
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else if (cached_write) begin
                        result_q <= '{dwv_pkg::STS_GOOD, dwv_pkg::KEY_NONE,
                            dwv_pkg::ASC_NONE, 1'b0};
                        state_q <= ST_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        state_q <= ST_MEDIA;
                    end
                end
                ST_MEDIA: begin
                    // fua and verify paths report only once the media has finished
                    if (med_done) begin
                        if (med_error) begin
                            result_q <= '{dwv_pkg::STS_CHECK, dwv_pkg::KEY_MEDIUM,
                                med_q.op == dwv_pkg::MOP_WRITE ? dwv_pkg::ASC_WRITE_ERR
                                : dwv_pkg::ASC_READ_ERR, 1'b0};
                        end else if (med_q.compare && miss) begin
                            result_q <= '{dwv_pkg::STS_CHECK, dwv_pkg::KEY_MISCOMPARE,
                                dwv_pkg::ASC_COMPARE, 1'b0};
                        end else begin
                            result_q <= '{dwv_pkg::STS_GOOD, dwv_pkg::KEY_NONE,
                                dwv_pkg::ASC_NONE, 1'b0};
                        end
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // media command and compare
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            med_q <= '{dwv_pkg::MOP_SEEK, 32'h00000000, 17'h00000, 1'b0};
            med_start_q <= 1'b0;
            early_q <= 1'b0;
        end else begin
            med_start_q <= 1'b0;
            if (state_q == ST_DECODE && !deferred_q && is_data_cmd && !bad_field) begin
                // bytck off: media or ecc check only, initiator not asked for data
                med_q <= '{mop, lba_eff, count, bytck};
                med_start_q <= 1'b1;
                early_q <= cached_write;
            end else if (med_done) begin
                early_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mismatch_q <= 1'b0;
        end else if (pair_diff && med_q.compare) begin
            mismatch_q <= 1'b1;
        end else if (med_start_q) begin
            mismatch_q <= 1'b0;
        end
    end

    // a late fault on a write already reported good is parked for the next command
    always_ff @(posedge clock) begin
        if (reset) begin
            deferred_q <= 1'b0;
        end else if (early_q && med_done && med_error) begin
            deferred_q <= 1'b1;
        end else if (state_q == ST_DECODE) begin
            deferred_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            last_lba_q <= 32'h00000000;
            link_ok_q <= 1'b0;
            link_cmd_q <= 1'b0;
        end else begin
            if (med_start_q) begin
                last_lba_q <= (med_q.count == 17'h00000) ? med_q.lba
                    : med_q.lba + {15'h0000, med_q.count} - 32'h00000001;
                link_cmd_q <= link_bit;
            end
            // an unlinked command closes the group, so relative addressing expires
            if (done_q) begin
                // a cached write finishes in the cycle its start is issued
                link_ok_q <= (med_start_q ? link_bit : link_cmd_q)
                    && result_q.status == dwv_pkg::STS_GOOD
                    && opcode != dwv_pkg::OP_TEST_READY;
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign med_cmd = med_q;
    assign med_start = med_start_q;
    assign cmd_done = done_q;

    // ************************************************************
    // checks
    // ************************************************************
    not_ready_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_DECODE && opcode == dwv_pkg::OP_TEST_READY && !deferred_q && !spin_q
        |=> done_q && result_q.key == dwv_pkg::KEY_NOT_READY)
        else $error("not ready check not reported");
    ready_good_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_DECODE && opcode == dwv_pkg::OP_TEST_READY && !deferred_q && spin_q
        |=> result_q.status == dwv_pkg::STS_GOOD && !med_start_q)
        else $error("ready check not good");
    short_count_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_DECODE && opcode == dwv_pkg::OP_WRITE6 && cdb_q[39:32] == 8'h00
        && !deferred_q && !bad_field |=> med_start_q && med_q.count == 17'h00100)
        else $error("short write zero count not 256");
    bytck_limit_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_DECODE && bytck && count > dwv_pkg::BYTCK_MAX_BLOCKS && !deferred_q
        |=> !med_start_q && result_q.key == dwv_pkg::KEY_ILLEGAL)
        else $error("byte check length limit missed");
    no_compare_a: assert property (@(posedge clock) disable iff (reset)
        med_start_q && med_q.op == dwv_pkg::MOP_VERIFY |-> med_q.compare == b1[1])
        else $error("verify compare flag wrong");
    fua_wait_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_MEDIA && !med_done |=> !done_q)
        else $error("status before media done");
    miscompare_a: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_MEDIA && med_done && !med_error && med_q.compare && miss
        |=> result_q.key == dwv_pkg::KEY_MISCOMPARE && done_q)
        else $error("miscompare not reported");
    deferred_set_a: assert property (@(posedge clock) disable iff (reset)
        early_q && med_done && med_error |=> deferred_q ##0 busy_q == 1'b0)
        else $error("deferred error lost");
    wait_pulse_a: assert property (@(posedge clock) disable iff (reset)
        !wait_q |=> wait_q)
        else $error("waitrequest low too long");
endmodule

// file: src/dwv_pkg.sv
// package for the disk write/verify command decoder: register map, opcodes, sense codes, types
// assumes a 32-bit Avalon-MM word-addressed slave and a 512-byte logical block
package dwv_pkg;
    // ************************************************************
    // register map (word index on the Avalon address)
    // ************************************************************
    localparam logic [3:0] REG_CDB_LO = 4'h0;
    localparam logic [3:0] REG_CDB_MID = 4'h1;
    localparam logic [3:0] REG_CDB_HI = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LAST_LBA = 4'h5;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WCE_BIT = 1;
    localparam logic CTRL_WCE_RESET = 1'b0;
    // ************************************************************
    // descriptor layout
    // ************************************************************
    localparam logic [7:0] OP_TEST_READY = 8'h00;
    localparam logic [7:0] OP_WRITE6 = 8'h0A;
    localparam logic [7:0] OP_WRITE10 = 8'h2A;
    localparam logic [7:0] OP_WRITE_VERIFY = 8'h2E;
    localparam logic [7:0] OP_VERIFY = 8'h2F;
    localparam int B1_RELADR = 0;
    localparam int B1_BYTCK = 1;
    localparam int B1_FUA = 3;
    localparam int B1_DPO = 4;
    localparam int CTRL_LINK = 0;
    localparam logic [16:0] WRITE6_ZERO_COUNT = 17'h00100;
    localparam int BLOCK_BYTES = 512;
    localparam int BYTCK_MAX_BYTES = 32768;
    localparam logic [16:0] BYTCK_MAX_BLOCKS = 17'(BYTCK_MAX_BYTES / BLOCK_BYTES);
    // ************************************************************
    // status and sense
    // ************************************************************
    localparam logic [7:0] STS_GOOD = 8'h00;
    localparam logic [7:0] STS_CHECK = 8'h02;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_NOT_READY = 4'h2;
    localparam logic [3:0] KEY_MEDIUM = 4'h3;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [3:0] KEY_MISCOMPARE = 4'hE;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_NOT_READY = 8'h04;
    localparam logic [7:0] ASC_WRITE_ERR = 8'h0C;
    localparam logic [7:0] ASC_READ_ERR = 8'h11;
    localparam logic [7:0] ASC_COMPARE = 8'h1D;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;

    typedef enum logic [1:0] {
        MOP_SEEK = 2'h0,
        MOP_WRITE = 2'h1,
        MOP_VERIFY = 2'h2,
        MOP_WRITE_VERIFY = 2'h3
    } dwv_mop_t;

    typedef struct packed {
        logic [7:0] status;
        logic [3:0] key;
        logic [7:0] asc;
        logic deferred;
    } dwv_result_t;

    typedef struct packed {
        dwv_mop_t op;
        logic [31:0] lba;
        logic [16:0] count;
        logic compare;
    } dwv_media_t;
endpackage
